// >>> design/dram_pd_map.svh
// register map, field positions, reset values and timing figures
// Behaviour
// - decode off one clock after clock-enable low
// - frozen power-down termination follows input asynchronously
// - leveling returns sampled clock level on data
// - cycle limit is picoseconds over period, rounded down
`ifndef DRAM_PD_MAP_SVH
`define DRAM_PD_MAP_SVH

// ---------------------------------------------------------------
// register offsets and fields
// ---------------------------------------------------------------
`define REG_LAT        4'h0
`define REG_CTRL       4'h4
`define REG_STAT       4'h8
`define LAT_RL_LSB     0
`define LAT_WL_LSB     8
`define LAT_WR_LSB     16
`define CTRL_CHOP_BIT  0
`define CTRL_FROZ_BIT  1
`define STAT_PD_BIT    0
`define STAT_DOFF_BIT  1
`define STAT_LVL_BIT   2
`define STAT_TERM_BIT  3
`define STAT_VIOL_BIT  4
`define RST_RL         5'h0B
`define RST_WL         5'h08
`define RST_WR         5'h0A

// ---------------------------------------------------------------
// command pin codes
// ---------------------------------------------------------------
`define CMD_NOP        4'h0
`define CMD_ACT        4'h1
`define CMD_PRE        4'h2
`define CMD_PREA       4'h3
`define CMD_REF        4'h4
`define CMD_RD         4'h5
`define CMD_RDA        4'h6
`define CMD_WR         4'h7
`define CMD_WRA        4'h8
`define CMD_MRS        4'h9

// ---------------------------------------------------------------
// timing figures (ps and clocks)
// ---------------------------------------------------------------
`define TXP_PS         6000
`define TXP_NCK        3
`define TXPDLL_PS      24000
`define TXPDLL_NCK     10
`define TCKE_PS        5000
`define TCKE_SLOW_PS   5625
`define TCKE_NCK       3
`define TREFI_PS       7800000
`define PD_MAX_REFI    9
`define CPDED_NCK      1
`define CMD_PDEN_NCK   1
`define RD_PDEN_ADD    5
`define WR_PDEN_ADD    4
`define WR_CHOP_ADD    2
`define TERM_SHORT_NCK 4
`define TERM_LONG_NCK  6
`define LVL_STROBE_NCK 40
`define LVL_DRIVE_NCK  25
`define TERM_ASYNC_MIN_PS 2000
`define TERM_ASYNC_MAX_PS 8500
`define LVL_OUT_MAX_PS    7500
`define LVL_OUT_SLOW_PS   9000

`endif

// >>> design/dram_pd_pkg.sv
// types shared by the power-down and termination timing block
package dram_pd_pkg;

  typedef enum logic [1:0] {ST_ACTIVE, ST_ENTRY, ST_DOWN} pd_state_t;

  typedef struct packed {
    logic        ck_q;
    logic        pd_on;
    logic        strobe_q;
    pd_state_t   st;
    logic [15:0] pd_cnt;
    logic [15:0] xp_cnt;
    logic [15:0] xpdll_cnt;
    logic [15:0] pden_cnt;
    logic [7:0]  odt_cnt;
    logic [3:0]  odt_need;
    logic        odt_q;
    logic        lvl;
    logic [7:0]  lvl_cnt;
    logic        term_on;
    logic        lvl_dq;
    logic        lvl_oe;
    logic        viol;
    logic [4:0]  read_latency;
    logic [4:0]  write_latency;
    logic [4:0]  wr_prog;
    logic        chop_four_fixed;
    logic        dll_frozen;
    logic [31:0] rdata;
  } dev_state_t;

endpackage : dram_pd_pkg

// >>> design/pin_sync.sv
// two-flip-flop synchroniser for a group of pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign q = s_r.sync;

endmodule : pin_sync
`default_nettype wire

// >>> design/dram_powerdown_odt_timing.sv
// power-down, termination and write-leveling timing of the memory
`timescale 1ns/100ps
`default_nettype none
`include "dram_pd_map.svh"
module dram_powerdown_odt_timing #(
  parameter int TCK_PS     = 200000,
  parameter int TWR_PS     = 15000,
  parameter int MOD_NCK    = 12,
  parameter bit SLOW_GRADE = 1'b0
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CK,
  input  wire logic        CKE,
  input  wire logic [3:0]  CMD,
  input  wire logic        TERM,
  input  wire logic        BURST_CHOP,
  input  wire logic        MRS_LEVEL,
  input  wire logic        STROBE,
  input  wire logic        STROBE_EN,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             TERM_ON,
  output logic             LEVEL_DQ,
  output logic             LEVEL_DQ_OE,
  output logic             PD_ACTIVE,
  output logic             VIOLATION
);
  import dram_pd_pkg::*;

  // ---------------------------------------------------------------
  // cycle counts: larger of clock term and time term (write recovery: time term only), rounded up except the power-down maximum
  // ---------------------------------------------------------------
  function automatic int ceil_ck(input int ps);
    ceil_ck = (ps + TCK_PS - 1) / TCK_PS;
  endfunction : ceil_ck

  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction : max2

  localparam int CKE_PS   = SLOW_GRADE ? `TCKE_SLOW_PS : `TCKE_PS;
  localparam int XP_I     = max2(`TXP_NCK, ceil_ck(`TXP_PS));
  localparam int XPDLL_I  = max2(`TXPDLL_NCK, ceil_ck(`TXPDLL_PS));
  localparam int CKE_I    = max2(`TCKE_NCK, ceil_ck(CKE_PS));
  localparam int PDMAX_I  = max2(1, (`PD_MAX_REFI * `TREFI_PS) / TCK_PS);
  localparam int TWR_I    = ceil_ck(TWR_PS);
  localparam logic [15:0] XP_CK    = 16'(XP_I);
  localparam logic [15:0] XPDLL_CK = 16'(XPDLL_I);
  localparam logic [15:0] CKE_MIN  = 16'(CKE_I);
  localparam logic [15:0] PD_MAX   = 16'(PDMAX_I);
  localparam logic [15:0] TWR_CK   = 16'(TWR_I);
  localparam logic [15:0] MOD_CK   = 16'(MOD_NCK);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [10:0] pins_s;
  logic        p_ck;
  logic        p_cke;
  logic [3:0]  p_cmd;
  logic        p_term;
  logic        p_chop;
  logic        p_mrs_lvl;
  logic        p_strobe;
  logic        p_strobe_en;

  pin_sync #(.WIDTH(11)) u_sync (
    .CLK (CLK),
    .RST (RST),
    .d   ({CK, CKE, CMD, TERM, BURST_CHOP, MRS_LEVEL, STROBE,
           STROBE_EN}),
    .q   (pins_s)
  );

  assign {p_ck, p_cke, p_cmd, p_term, p_chop, p_mrs_lvl, p_strobe,
          p_strobe_en} = pins_s;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  dev_state_t  s_r;
  dev_state_t  s_nxt;
  logic        ck_rise;
  logic        strobe_rise;
  logic        viol_set;
  logic        is_cmd;
  logic        is_write;
  logic [15:0] wr_base;
  logic [15:0] need;
  logic [15:0] xp_rem;
  logic [15:0] xpdll_rem;
  logic [15:0] pden_rem;

  always_comb
  begin
    s_nxt       = s_r;
    viol_set    = 1'b0;
    need        = 16'h0000;
    ck_rise     = p_ck & ~s_r.ck_q;
    strobe_rise = p_strobe & ~s_r.strobe_q;
    is_cmd      = (p_cmd != `CMD_NOP);
    is_write    = (p_cmd == `CMD_WR) || (p_cmd == `CMD_WRA);
    xp_rem      = (s_r.xp_cnt == 16'h0000) ? 16'h0000
                                           : s_r.xp_cnt - 16'h0001;
    xpdll_rem   = (s_r.xpdll_cnt == 16'h0000) ? 16'h0000
                                              : s_r.xpdll_cnt - 16'h0001;
    pden_rem    = (s_r.pden_cnt == 16'h0000) ? 16'h0000
                                             : s_r.pden_cnt - 16'h0001;
    wr_base     = 16'(s_r.write_latency) + (s_r.chop_four_fixed
                  ? 16'(`WR_CHOP_ADD) : 16'(`WR_PDEN_ADD));
    s_nxt.ck_q     = p_ck;
    s_nxt.strobe_q = p_strobe;

    // ---------------------------------------------------------------
    // register writes and read data
    // ---------------------------------------------------------------
    s_nxt.rdata = 32'h0000_0000;
    if (WR && ADDR == `REG_LAT)
    begin
      s_nxt.read_latency  = WDATA[`LAT_RL_LSB +: 5];
      s_nxt.write_latency = WDATA[`LAT_WL_LSB +: 5];
      s_nxt.wr_prog       = WDATA[`LAT_WR_LSB +: 5];
    end
    if (WR && ADDR == `REG_CTRL)
    begin
      s_nxt.chop_four_fixed = WDATA[`CTRL_CHOP_BIT];
      s_nxt.dll_frozen      = WDATA[`CTRL_FROZ_BIT];
    end
    if (WR && ADDR == `REG_STAT && WDATA[`STAT_VIOL_BIT])
      s_nxt.viol = 1'b0;
    if (RD)
    begin
      case (ADDR)
        `REG_LAT:
        begin
          s_nxt.rdata[`LAT_RL_LSB +: 5] = s_r.read_latency;
          s_nxt.rdata[`LAT_WL_LSB +: 5] = s_r.write_latency;
          s_nxt.rdata[`LAT_WR_LSB +: 5] = s_r.wr_prog;
        end
        `REG_CTRL:
        begin
          s_nxt.rdata[`CTRL_CHOP_BIT] = s_r.chop_four_fixed;
          s_nxt.rdata[`CTRL_FROZ_BIT] = s_r.dll_frozen;
        end
        `REG_STAT:
        begin
          s_nxt.rdata[`STAT_PD_BIT]   = (s_r.st != ST_ACTIVE);
          s_nxt.rdata[`STAT_DOFF_BIT] = (s_r.st == ST_DOWN);
          s_nxt.rdata[`STAT_LVL_BIT]  = s_r.lvl;
          s_nxt.rdata[`STAT_TERM_BIT] = s_r.term_on;
          s_nxt.rdata[`STAT_VIOL_BIT] = s_r.viol;
        end
        default:
          s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // ---------------------------------------------------------------
    // link clock edge: power-down sequencing and command checks
    // ---------------------------------------------------------------
    if (ck_rise)
    begin
      s_nxt.xp_cnt    = xp_rem;
      s_nxt.xpdll_cnt = xpdll_rem;
      s_nxt.pden_cnt  = pden_rem;
      case (s_r.st)
        ST_ACTIVE:
        begin
          if (!p_cke)
          begin
            s_nxt.st     = ST_ENTRY;
            s_nxt.pd_cnt = 16'h0000;
            if (pden_rem != 16'h0000)
              viol_set = 1'b1;
            if (is_cmd)
              viol_set = 1'b1;
          end
          else if (is_cmd)
          begin
            if (xp_rem != 16'h0000)
              viol_set = 1'b1;
            if ((p_cmd == `CMD_RD || p_cmd == `CMD_RDA) &&
                xpdll_rem != 16'h0000)
              viol_set = 1'b1;
            case (p_cmd)
              `CMD_ACT, `CMD_PRE, `CMD_PREA, `CMD_REF:
                need = 16'(`CMD_PDEN_NCK);
              `CMD_RD, `CMD_RDA:
                need = 16'(s_r.read_latency) + 16'(`RD_PDEN_ADD);
              `CMD_WR:
                need = wr_base + TWR_CK;
              `CMD_WRA:
                need = wr_base + 16'(s_r.wr_prog) + 16'h0001;
              `CMD_MRS:
                need = MOD_CK;
              default:
                need = 16'h0000;
            endcase
            if (need > pden_rem)
              s_nxt.pden_cnt = need;
            if (p_cmd == `CMD_MRS)
            begin
              s_nxt.lvl     = p_mrs_lvl;
              s_nxt.lvl_cnt = 8'h00;
              s_nxt.lvl_oe  = 1'b0;
            end
          end
        end
        ST_ENTRY, ST_DOWN:
        begin
          // decoding stops one edge after the low clock enable
          if (s_r.st == ST_ENTRY)
            s_nxt.st = ST_DOWN;
          if (s_r.pd_cnt != 16'hFFFF)
            s_nxt.pd_cnt = s_r.pd_cnt + 16'h0001;
          if (s_r.pd_cnt == PD_MAX)
            viol_set = 1'b1;
          if (p_cke)
          begin
            s_nxt.st        = ST_ACTIVE;
            s_nxt.xp_cnt    = XP_CK;
            s_nxt.xpdll_cnt = s_r.dll_frozen ? XPDLL_CK : XP_CK;
            if (s_r.pd_cnt + 16'h0001 < CKE_MIN)
              viol_set = 1'b1;
          end
        end
        default:
          s_nxt.st = ST_ACTIVE;
      endcase

      // termination pulse width
      s_nxt.odt_q = p_term;
      if (p_term && !s_r.odt_q)
      begin
        s_nxt.odt_cnt  = 8'h01;
        s_nxt.odt_need = (is_write && !p_chop && !s_r.chop_four_fixed)
                         ? 4'(`TERM_LONG_NCK)
                         : 4'(`TERM_SHORT_NCK);
      end
      else if (p_term && s_r.odt_cnt != 8'hFF)
        s_nxt.odt_cnt = s_r.odt_cnt + 8'h01;
      if (!p_term && s_r.odt_q && s_r.odt_cnt < 8'(s_r.odt_need))
        viol_set = 1'b1;

      if (s_r.lvl && s_r.lvl_cnt != 8'hFF)
        s_nxt.lvl_cnt = s_r.lvl_cnt + 8'h01;
      if (s_r.st == ST_ACTIVE || p_cke)
        s_nxt.term_on = p_term;
    end

    // frozen-loop power-down: termination tracks the pin directly
    if (s_r.st == ST_DOWN && s_r.dll_frozen)
      s_nxt.term_on = p_term;

    // ---------------------------------------------------------------
    // write leveling
    // ---------------------------------------------------------------
    if (s_r.lvl)
    begin
      if (p_strobe_en && s_r.lvl_cnt < 8'(`LVL_DRIVE_NCK))
        viol_set = 1'b1;
      if (strobe_rise)
      begin
        if (s_r.lvl_cnt < 8'(`LVL_STROBE_NCK))
          viol_set = 1'b1;
        s_nxt.lvl_dq = p_ck;
        s_nxt.lvl_oe = 1'b1;
      end
    end
    else
      s_nxt.lvl_oe = 1'b0;

    s_nxt.pd_on = (s_nxt.st != ST_ACTIVE);

    if (viol_set)
      s_nxt.viol = 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s_r               <= '0;
      s_r.st            <= ST_ACTIVE;
      s_r.odt_need      <= 4'(`TERM_SHORT_NCK);
      s_r.read_latency  <= `RST_RL;
      s_r.write_latency <= `RST_WL;
      s_r.wr_prog       <= `RST_WR;
    end
    else
      s_r <= s_nxt;
  end

  assign RDATA       = s_r.rdata;
  assign TERM_ON     = s_r.term_on;
  assign LEVEL_DQ    = s_r.lvl_dq;
  assign LEVEL_DQ_OE = s_r.lvl_oe;
  assign PD_ACTIVE   = s_r.pd_on;
  assign VIOLATION   = s_r.viol;

endmodule : dram_powerdown_odt_timing
`default_nettype wire

// >>> tb/pd_monitor.sv
// checker for the power-down, termination and register port behaviour
`timescale 1ns/100ps
`default_nettype none
module pd_monitor (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CKE,
  input wire logic        TERM,
  input wire logic        STROBE,
  input wire logic [3:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        TERM_ON,
  input wire logic        LEVEL_DQ_OE,
  input wire logic        PD_ACTIVE,
  input wire logic        VIOLATION
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_stat_read;
    RD && ADDR == 4'h8;
  endsequence

  a_reset_quiet: assert property (
    $fell(RST) |-> !PD_ACTIVE && !VIOLATION && !TERM_ON && RDATA == 32'h0)
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data outside read answer");
  a_stat_mirror: assert property (
    s_stat_read |=> RDATA[0] == $past(PD_ACTIVE)
                    && RDATA[4] == $past(VIOLATION))
    else $error("status read differs from outputs");
  a_unmapped_zero: assert property (RD && ADDR == 4'hC |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_viol_sticky: assert property (
    VIOLATION && !(WR && ADDR == 4'h8 && WDATA[4]) |=> VIOLATION)
    else $error("violation dropped without clear");
  a_pd_entry: assert property (
    $rose(PD_ACTIVE) |-> !$past(CKE, 5))
    else $error("power-down without clock-enable low");
  a_pd_exit: assert property (
    $fell(PD_ACTIVE) |-> $past(CKE, 5))
    else $error("power-down left without clock-enable high");
  a_term_cause: assert property (
    $rose(TERM_ON) |-> $past(TERM, 2))
    else $error("termination on without control high");
  a_lvl_strobe: assert property (
    $rose(LEVEL_DQ_OE) |-> $past(STROBE, 2))
    else $error("leveling output without strobe edge");
endmodule : pd_monitor

bind dram_powerdown_odt_timing pd_monitor pd_monitor_i (
  .CLK, .RST, .CKE, .TERM, .STROBE, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .TERM_ON, .LEVEL_DQ_OE, .PD_ACTIVE, .VIOLATION
);
`default_nettype wire

// >>> tb/ctl_model.sv
// controller-side model driving link clock, command, termination, strobe
`timescale 1ns/100ps
`default_nettype none
module ctl_model (
  output var logic       CK,
  output var logic       CKE,
  output var logic [3:0] CMD,
  output var logic       TERM,
  output var logic       BURST_CHOP,
  output var logic       MRS_LEVEL,
  output var logic       STROBE,
  output var logic       STROBE_EN
);
  initial
  begin
    CK = 1'b0;
    CKE = 1'b1;
    CMD = 4'h0;
    TERM = 1'b0;
    BURST_CHOP = 1'b0;
    MRS_LEVEL = 1'b0;
    STROBE = 1'b0;
    STROBE_EN = 1'b0;
  end

  // link clock runs free, 200 ns
  always #100 CK = ~CK;

  // pins change at the falling edge, stable for the next rise
  task automatic step(input logic cke, input logic [3:0] cmd,
                      input logic term, input logic lvl);
  begin
    @(negedge CK);
    CKE <= cke;
    CMD <= cmd;
    TERM <= term;
    MRS_LEVEL <= lvl;
    @(posedge CK);
  end
  endtask : step

  // on-the-fly chop flag, held until changed
  task automatic chop(input logic c);
  begin
    @(negedge CK);
    BURST_CHOP <= c;
  end
  endtask : chop

  // strobe moves with the clock rise, so leveling sees the clock high;
  // undriven strobe is forced low by gating it with the enable
  task automatic strobe(input logic en, input logic s);
  begin
    @(posedge CK);
    STROBE_EN <= en;
    STROBE <= s & en;
  end
  endtask : strobe
endmodule : ctl_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the power-down and termination timing block
`timescale 1ns/100ps
`default_nettype none
`include "dram_pd_map.svh"
module testbench;
  typedef struct {
    logic [3:0] pre;
    int         gap;
    logic [3:0] first;
    int         len;
    logic       viol;
  } row_t;

  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic [3:0]  ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  wire logic   CK, CKE, TERM, BURST_CHOP, MRS_LEVEL, STROBE, STROBE_EN;
  wire logic   TERM_ON, LEVEL_DQ, LEVEL_DQ_OE, PD_ACTIVE, VIOLATION;
  wire logic [3:0]  CMD;
  wire logic [31:0] RDATA;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;
  row_t        rows [12] = '{
    '{`CMD_ACT, 0, `CMD_NOP, 4, 1'b0},
    '{`CMD_PRE, 0, `CMD_NOP, 4, 1'b0},
    '{`CMD_REF, 0, `CMD_NOP, 4, 1'b0},
    '{`CMD_NOP, 0, `CMD_ACT, 4, 1'b1},
    '{`CMD_NOP, 0, `CMD_NOP, 1, 1'b1},
    '{`CMD_RD, 2, `CMD_NOP, 4, 1'b1},
    '{`CMD_RD, 16, `CMD_NOP, 4, 1'b0},
    '{`CMD_WR, 4, `CMD_NOP, 4, 1'b1},
    '{`CMD_WR, 13, `CMD_NOP, 4, 1'b0},
    '{`CMD_WRA, 14, `CMD_NOP, 4, 1'b1},
    '{`CMD_MRS, 3, `CMD_NOP, 4, 1'b1},
    '{`CMD_MRS, 12, `CMD_NOP, 4, 1'b0}
  };

  always #12.5 CLK = ~CLK;

  dram_powerdown_odt_timing dram_powerdown_odt_timing_i (
    .CLK, .RST, .CK, .CKE, .CMD, .TERM, .BURST_CHOP, .MRS_LEVEL, .STROBE,
    .STROBE_EN, .ADDR, .WDATA, .WR, .RD, .RDATA, .TERM_ON, .LEVEL_DQ,
    .LEVEL_DQ_OE, .PD_ACTIVE, .VIOLATION
  );
  ctl_model ctl_model_i (
    .CK, .CKE, .CMD, .TERM, .BURST_CHOP, .MRS_LEVEL, .STROBE, .STROBE_EN
  );

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
  begin
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
  begin
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  end
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [3:0] a,
                        input logic [31:0] exp);
  begin
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    check(name, RDATA, exp);
  end
  endtask : rd_chk

  task automatic nops(input int n);
  begin
    repeat (n) ctl_model_i.step(1'b1, `CMD_NOP, 1'b0, 1'b0);
  end
  endtask : nops

  task automatic viol_chk(input logic exp);
  begin
    check("violation", VIOLATION, exp);
    wr_reg(4'h8, 32'h10);
  end
  endtask : viol_chk

  task automatic pd(input int len, input logic [3:0] first);
  begin
    ctl_model_i.step(1'b0, first, 1'b0, 1'b0);
    repeat (len - 1) ctl_model_i.step(1'b0, `CMD_NOP, 1'b0, 1'b0);
    if (len > 1)
      check("pd on", PD_ACTIVE, 1'b1);
    ctl_model_i.step(1'b1, `CMD_NOP, 1'b0, 1'b0);
    nops(4);
    check("pd off", PD_ACTIVE, 1'b0);
  end
  endtask : pd

  task automatic term_run(input logic [3:0] cmd, input int n,
                          input logic exp);
  begin
    ctl_model_i.step(1'b1, cmd, 1'b1, 1'b0);
    repeat (n - 1) ctl_model_i.step(1'b1, `CMD_NOP, 1'b1, 1'b0);
    check("term on", TERM_ON, 1'b1);
    nops(3);
    check("term off", TERM_ON, 1'b0);
    viol_chk(exp);
  end
  endtask : term_run

  // ---------------------------------------------------------------
  // timeout and main sequence
  // ---------------------------------------------------------------
  always @(posedge CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures = failures + 1;
      print_verdict;
    end
  end

  initial
  begin
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    #1;
    check("pd rst", PD_ACTIVE, 1'b0);
    check("oe rst", LEVEL_DQ_OE, 1'b0);
    rd_chk("lat rst", 4'h0, 32'h000A080B);
    rd_chk("ctrl rst", 4'h4, 32'h0);
    wr_reg(4'h4, 32'h3);
    rd_chk("ctrl", 4'h4, 32'h3);
    wr_reg(4'hC, 32'h1);
    rd_chk("unmapped", 4'hC, 32'h0);
    wr_reg(4'h4, 32'h0);
    nops(4);
    foreach (rows[i])
    begin
      ctl_model_i.step(1'b1, rows[i].pre, 1'b0, 1'b0);
      nops(rows[i].gap);
      pd(rows[i].len, rows[i].first);
      viol_chk(rows[i].viol);
    end
    pd(351, `CMD_NOP);
    viol_chk(1'b0);
    pd(352, `CMD_NOP);
    viol_chk(1'b1);
    pd(4, `CMD_NOP);
    ctl_model_i.step(1'b0, `CMD_NOP, 1'b0, 1'b0);
    repeat (3) ctl_model_i.step(1'b0, `CMD_NOP, 1'b0, 1'b0);
    rd_chk("stat pd", 4'h8, 32'h3);
    ctl_model_i.step(1'b1, `CMD_NOP, 1'b0, 1'b0);
    ctl_model_i.step(1'b1, `CMD_ACT, 1'b0, 1'b0);
    nops(3);
    viol_chk(1'b1);
    term_run(`CMD_NOP, 3, 1'b1);
    term_run(`CMD_NOP, 4, 1'b0);
    term_run(`CMD_WR, 5, 1'b1);
    term_run(`CMD_WR, 6, 1'b0);
    ctl_model_i.chop(1'b1);
    term_run(`CMD_WR, 4, 1'b0);
    ctl_model_i.chop(1'b0);
    wr_reg(4'h4, 32'h1);
    ctl_model_i.step(1'b1, `CMD_WR, 1'b0, 1'b0);
    nops(10);
    pd(4, `CMD_NOP);
    viol_chk(1'b0);
    ctl_model_i.step(1'b1, `CMD_WRA, 1'b0, 1'b0);
    nops(20);
    pd(4, `CMD_NOP);
    viol_chk(1'b0);
    wr_reg(4'h4, 32'h2);
    pd(4, `CMD_NOP);
    ctl_model_i.step(1'b1, `CMD_RD, 1'b0, 1'b0);
    nops(1);
    viol_chk(1'b1);
    wr_reg(4'h4, 32'h0);
    ctl_model_i.step(1'b1, `CMD_MRS, 1'b0, 1'b1);
    nops(5);
    ctl_model_i.strobe(1'b1, 1'b1);
    nops(3);
    ctl_model_i.strobe(1'b0, 1'b0);
    ctl_model_i.step(1'b1, `CMD_MRS, 1'b0, 1'b0);
    viol_chk(1'b1);
    nops(12);
    ctl_model_i.step(1'b1, `CMD_MRS, 1'b0, 1'b1);
    nops(30);
    ctl_model_i.strobe(1'b1, 1'b0);
    nops(12);
    ctl_model_i.strobe(1'b1, 1'b1);
    nops(2);
    check("level oe", LEVEL_DQ_OE, 1'b1);
    check("level dq", LEVEL_DQ, 1'b1);
    viol_chk(1'b0);
    ctl_model_i.strobe(1'b0, 1'b0);
    ctl_model_i.step(1'b1, `CMD_MRS, 1'b0, 1'b0);
    nops(2);
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
